// *** rtl/tocu_cfg.svh ***
// Constants for the timer output compare unit
`ifndef TOCU_CFG_SVH
`define TOCU_CFG_SVH
`define TOCU_BOTTOM 8'h00
`define TOCU_MAX 8'hFF
`define TOCU_ONE 8'h01
`define TOCU_ADDR_COUNT 3'h0
`define TOCU_ADDR_COMPARE 3'h1
`define TOCU_ADDR_CTRL 3'h2
`define TOCU_ADDR_FLAGS 3'h3
`define TOCU_ADDR_MASK 3'h4
`define TOCU_CTRL_WGM_LSB 0
`define TOCU_CTRL_COM_LSB 2
`define TOCU_CTRL_CS_BIT 4
`define TOCU_CTRL_FOC_BIT 7
`define TOCU_FLAG_OCF_BIT 0
`define TOCU_FLAG_TOV_BIT 1
`endif

// *** rtl/tocu_pkg.sv ***
// Types for the timer output compare unit
package tocu_pkg;
  typedef enum logic [1:0]
  {
    TOCU_WGM_NORMAL = 2'h0,
    TOCU_WGM_PCPWM = 2'h1,
    TOCU_WGM_CTC = 2'h2,
    TOCU_WGM_FAST = 2'h3
  } tocu_wgm_t;
  typedef enum logic [1:0]
  {
    TOCU_COM_NONE = 2'h0,
    TOCU_COM_TOGGLE = 2'h1,
    TOCU_COM_CLEAR = 2'h2,
    TOCU_COM_SET = 2'h3
  } tocu_com_t;
  // Count direction, Gray ordered
  typedef enum logic [0:0]
  {
    TOCU_DIR_UP = 1'b0,
    TOCU_DIR_DOWN = 1'b1
  } tocu_dir_t;
endpackage : tocu_pkg

// *** rtl/tocu_counter.sv ***
// Up/down 8-bit counter with mode dependent sequence
`timescale 1ns/100ps
`default_nettype none
`include "tocu_cfg.svh"
module tocu_counter
  import tocu_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire tocu_wgm_t mode,
  input wire logic [WIDTH-1:0] top_value,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output tocu_dir_t dir
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  tocu_dir_t dir_reg;
  tocu_dir_t dir_next;
  wire logic at_max = (count_reg == WIDTH'(`TOCU_MAX));
  wire logic at_bot = (count_reg == WIDTH'(`TOCU_BOTTOM));
  wire logic ctc_hit = (mode == TOCU_WGM_CTC) && (count_reg == top_value);
  wire logic turn_down = (mode == TOCU_WGM_PCPWM) && at_max;
  wire logic turn_up = (mode != TOCU_WGM_PCPWM) || at_bot;
  wire tocu_dir_t dir_tick = turn_down ? TOCU_DIR_DOWN : (turn_up ? TOCU_DIR_UP : dir_reg);
  wire logic go_down = (dir_tick == TOCU_DIR_DOWN);
  wire logic [WIDTH-1:0] count_step = go_down ? count_reg - WIDTH'(`TOCU_ONE)
                                              : count_reg + WIDTH'(`TOCU_ONE);
  // CPU write beats clear and count; wrap is natural at 8 bits
  assign count_next = load ? load_value
                    : !tick ? count_reg
                    : ctc_hit ? WIDTH'(`TOCU_BOTTOM)
                    : count_step;
  assign dir_next = (tick && !load) ? dir_tick : dir_reg;
  // ************************************
  // Counter state
  // ************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= WIDTH'(`TOCU_BOTTOM);
      dir_reg <= TOCU_DIR_UP;
    end
    else
    begin
      count_reg <= count_next;
      dir_reg <= dir_next;
    end
  end
  assign count = count_reg;
  assign dir = dir_reg;
endmodule : tocu_counter
`default_nettype wire

// *** rtl/tocu_wavegen.sv ***
// Waveform generator holding the compare output state
`timescale 1ns/100ps
`default_nettype none
`include "tocu_cfg.svh"
module tocu_wavegen
  import tocu_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire tocu_wgm_t mode,
  input wire tocu_com_t action,
  input wire tocu_dir_t dir,
  input wire logic match,
  input wire logic force_cmp,
  input wire logic at_bottom,
  input wire logic cmp_is_max,
  output logic oc_state
);
  logic oc_reg;
  logic oc_next;
  wire logic pwm = (mode == TOCU_WGM_PCPWM) || (mode == TOCU_WGM_FAST);
  wire logic inv = (action == TOCU_COM_SET);
  wire logic pwm_act = (action == TOCU_COM_CLEAR) || (action == TOCU_COM_SET);
  // Non-PWM match action, shared by real and forced matches
  function automatic logic np_action(input tocu_com_t a, input logic cur);
    case (a)
      TOCU_COM_TOGGLE: np_action = !cur;
      TOCU_COM_CLEAR: np_action = 1'b0;
      TOCU_COM_SET: np_action = 1'b1;
      default: np_action = cur;
    endcase
  endfunction : np_action
  // Fast PWM: match flips to inverse level, bottom restores; match at max wins
  wire logic fast_bot = tick && at_bottom && !cmp_is_max;
  // A stopped timer must not re-apply a standing match every clock
  wire logic fast_val = (tick && match) ? inv : (fast_bot ? !inv : oc_reg);
  wire logic pc_val = match ? (dir == TOCU_DIR_UP ? inv : !inv) : oc_reg;
  wire logic np_ev = (tick && match) || force_cmp;
  // Action bits act unbuffered from the next match on; mode change keeps state
  assign oc_next = (mode == TOCU_WGM_FAST && pwm_act) ? fast_val
                 : (mode == TOCU_WGM_PCPWM && pwm_act) ? (tick ? pc_val : oc_reg)
                 : (mode == TOCU_WGM_FAST && action == TOCU_COM_TOGGLE && tick && match)
                   ? !oc_reg
                 : (!pwm && np_ev) ? np_action(action, oc_reg)
                 : oc_reg;
  // ************************************
  // Output state
  // ************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      oc_reg <= 1'b0;
    else
      oc_reg <= oc_next;
  end
  assign oc_state = oc_reg;
endmodule : tocu_wavegen
`default_nettype wire

// *** rtl/tocu_top.sv ***
// Top of the timer output compare unit with register port
//
// Notes on behaviour
// - Compare counter and compare value every cycle
// - Match sets flag one timer tick later
// - Flag and enable raise interrupt request
// - Flag cleared by service or writing one
// - Compare buffered in PWM, direct otherwise
// - Buffer loads at top or bottom
// - CPU reaches buffer or active register
// - Force strobe drives output in non-PWM modes only, no flag
// - Counter write blocks next tick's match
// - Output state survives mode change
// - Action bits unbuffered, act next match
// - Nonzero action overrides port data
// - Action zero leaves output unchanged
// - Mode sets count, action sets output
// - Extreme compare values handled at max/bottom
// - Normal mode counts up and wraps
// - Overflow flag set when counter wraps from max to zero, or counts down to zero in mode one
// - Mode two clears counter on match
// - Mode three is single-slope fast PWM
// - Mode one is dual-slope phase-correct PWM
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tocu_cfg.svh"
module tocu_top
  import tocu_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic timer_tick,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic port_data,
  input wire logic output_pin_direction_bit,
  output logic compare_output,
  output logic compare_output_oe,
  output logic compare_irq,
  output logic overflow_irq
);
  // ************************************
  // Register decode
  // ************************************
  logic [WIDTH-1:0] compare_value_register;
  logic [WIDTH-1:0] compare_buffer_reg;
  logic [1:0] mode_reg;
  logic [1:0] action_reg;
  logic run_reg;
  logic compare_match_flag;
  logic overflow_flag;
  logic compare_interrupt_enable;
  logic overflow_interrupt_enable;
  logic block_reg;
  logic [7:0] rdata_reg;
  logic [WIDTH-1:0] timer_count_value;
  tocu_dir_t dir;
  logic oc_state;
  wire tocu_wgm_t waveform_mode_select = tocu_wgm_t'(mode_reg);
  wire tocu_com_t compare_output_action = tocu_com_t'(action_reg);
  wire logic wr_count = reg_write && (reg_addr == `TOCU_ADDR_COUNT);
  wire logic wr_cmp = reg_write && (reg_addr == `TOCU_ADDR_COMPARE);
  wire logic wr_ctrl = reg_write && (reg_addr == `TOCU_ADDR_CTRL);
  wire logic wr_flags = reg_write && (reg_addr == `TOCU_ADDR_FLAGS);
  wire logic wr_mask = reg_write && (reg_addr == `TOCU_ADDR_MASK);
  wire logic pwm_mode = (waveform_mode_select == TOCU_WGM_PCPWM)
                     || (waveform_mode_select == TOCU_WGM_FAST);
  // Timer only advances when running; CPU port is always live
  wire logic tick = timer_tick && run_reg;
  // Force strobe only acts in non-PWM modes and is never stored
  wire logic force_compare_strobe = wr_ctrl && reg_wdata[`TOCU_CTRL_FOC_BIT] && !pwm_mode;
  // A forced match uses the action bits written beside the strobe
  wire tocu_com_t force_action = tocu_com_t'(reg_wdata[`TOCU_CTRL_COM_LSB +: 2]);
  wire tocu_com_t wg_action = force_compare_strobe ? force_action : compare_output_action;
  // ************************************
  // Comparator and match gating
  // ************************************
  wire logic raw_match = (timer_count_value == compare_value_register);
  // Blocking lasts until the next timer tick has passed, even if stopped
  wire logic match = raw_match && !block_reg && !wr_count;
  wire logic at_bottom = (timer_count_value == WIDTH'(`TOCU_BOTTOM));
  wire logic at_max = (timer_count_value == WIDTH'(`TOCU_MAX));
  // Update point: max tick for fast PWM, max or bottom tick for phase correct
  wire logic upd_point = (waveform_mode_select == TOCU_WGM_FAST) ? at_max
                        : at_bottom || at_max;
  wire logic cmp_is_max = (compare_value_register == WIDTH'(`TOCU_MAX));
  // Overflow: counter wraps from max to zero in normal/ctc/fast, steps down to bottom in pc PWM
  wire logic ovf_normal = tick && at_max && !wr_count
                        && (waveform_mode_select != TOCU_WGM_PCPWM);
  wire logic ovf_pc = tick && !wr_count && (waveform_mode_select == TOCU_WGM_PCPWM)
                    && (timer_count_value == WIDTH'(`TOCU_ONE)) && (dir == TOCU_DIR_DOWN);
  wire logic ovf_event = ovf_normal || ovf_pc;
  // Flag set wins over any clear in the same cycle
  wire logic ocf_clr = compare_irq_ack || (wr_flags && reg_wdata[`TOCU_FLAG_OCF_BIT]);
  wire logic tov_clr = overflow_irq_ack || (wr_flags && reg_wdata[`TOCU_FLAG_TOV_BIT]);
  // Flag rises at the tick that ends the matching count value
  wire logic ocf_set = tick && match;
  wire logic [7:0] rd_mux =
    (reg_addr == `TOCU_ADDR_COUNT) ? 8'(timer_count_value) :
    (reg_addr == `TOCU_ADDR_COMPARE) ? 8'(pwm_mode ? compare_buffer_reg
                                                   : compare_value_register) :
    (reg_addr == `TOCU_ADDR_CTRL) ? {3'h0, run_reg, action_reg, mode_reg} :
    (reg_addr == `TOCU_ADDR_FLAGS) ? {6'h00, overflow_flag, compare_match_flag} :
    (reg_addr == `TOCU_ADDR_MASK) ? {6'h00, overflow_interrupt_enable,
                                     compare_interrupt_enable} :
    8'h00;
  // ************************************
  // Counter and waveform generator
  // ************************************
  tocu_counter #(.WIDTH(WIDTH)) u_counter
  (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .mode(waveform_mode_select),
    .top_value(compare_value_register),
    .load(wr_count),
    .load_value(reg_wdata[WIDTH-1:0]),
    .count(timer_count_value),
    .dir(dir)
  );
  tocu_wavegen u_wavegen
  (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .mode(waveform_mode_select),
    .action(wg_action),
    .dir(dir),
    .match(match),
    .force_cmp(force_compare_strobe),
    .at_bottom(at_bottom),
    .cmp_is_max(cmp_is_max),
    .oc_state(oc_state)
  );
  // ************************************
  // Configuration registers
  // ************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= 2'h0;
      action_reg <= 2'h0;
      run_reg <= 1'b0;
      compare_interrupt_enable <= 1'b0;
      overflow_interrupt_enable <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_reg <= reg_wdata[`TOCU_CTRL_WGM_LSB +: 2];
        action_reg <= reg_wdata[`TOCU_CTRL_COM_LSB +: 2];
        run_reg <= reg_wdata[`TOCU_CTRL_CS_BIT];
      end
      if (wr_mask)
      begin
        compare_interrupt_enable <= reg_wdata[`TOCU_FLAG_OCF_BIT];
        overflow_interrupt_enable <= reg_wdata[`TOCU_FLAG_TOV_BIT];
      end
    end
  end
  // Compare value: buffered in PWM, loaded at the update point
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      compare_buffer_reg <= WIDTH'(`TOCU_BOTTOM);
      compare_value_register <= WIDTH'(`TOCU_BOTTOM);
    end
    else
    begin
      if (wr_cmp)
        compare_buffer_reg <= reg_wdata[WIDTH-1:0];
      if (wr_cmp && !pwm_mode)
        compare_value_register <= reg_wdata[WIDTH-1:0];
      else if (pwm_mode && tick && upd_point)
        compare_value_register <= compare_buffer_reg;
    end
  end
  // ************************************
  // Flags, blocking and read data
  // ************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      block_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      // Flag follows match by one timer tick; set beats clear
      if (ocf_set)
        compare_match_flag <= 1'b1;
      else if (ocf_clr)
        compare_match_flag <= 1'b0;
      if (ovf_event)
        overflow_flag <= 1'b1;
      else if (tov_clr)
        overflow_flag <= 1'b0;
      if (wr_count)
        block_reg <= 1'b1;
      else if (tick)
        block_reg <= 1'b0;
      rdata_reg <= reg_read ? rd_mux : 8'h00;
    end
  end
  // ************************************
  // Outputs
  // ************************************
  assign reg_rdata = rdata_reg;
  assign compare_irq = compare_match_flag && compare_interrupt_enable;
  assign overflow_irq = overflow_flag && overflow_interrupt_enable;
  // Any nonzero action hands the pin data to the compare state
  assign compare_output = (action_reg != 2'h0) ? oc_state : port_data;
  // Direction stays with the port bit, so set state before enabling
  assign compare_output_oe = output_pin_direction_bit;
endmodule : tocu_top
`default_nettype wire

// *** tb/tocu_checker_asserts.sv ***
// Port checker for the timer output compare unit
`timescale 1ns/100ps
`default_nettype none
module tocu_checker
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic timer_tick,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic port_data,
  input wire logic output_pin_direction_bit,
  input wire logic compare_output,
  input wire logic compare_output_oe,
  input wire logic compare_irq,
  input wire logic overflow_irq
);
  // ****
  // Write decode
  // ****
  // Enable writes may raise a request without any tick
  wire logic en_wr = reg_write && reg_addr == 3'h4;
  wire logic fl_wr = reg_write && reg_addr == 3'h3;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Counter write then read, timer idle
  sequence s_cnt_wr;
    reg_write && reg_addr == 3'h0 && !timer_tick;
  endsequence
  sequence s_cnt_rd;
    reg_read && reg_addr == 3'h0 && !timer_tick;
  endsequence
  property p_cnt; s_cnt_wr ##1 s_cnt_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_cnt: assert property (p_cnt) else $error("counter readback wrong");
  property p_oe; compare_output_oe == output_pin_direction_bit; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pass; reg_write && reg_addr == 3'h2 && reg_wdata[3:2] == 2'h0
    |=> compare_output == port_data; endproperty
  a_pass: assert property (p_pass) else $error("port data not passed");
  property p_rise; $rose(compare_irq) |-> $past(timer_tick) || $past(en_wr); endproperty
  a_rise: assert property (p_rise) else $error("compare flag off tick");
  property p_hold; !timer_tick && !en_wr && !fl_wr && !compare_irq_ack |=> $stable(compare_irq);
  endproperty
  a_hold: assert property (p_hold) else $error("compare request moved");
  property p_ack; compare_irq_ack && !timer_tick |=> !compare_irq; endproperty
  a_ack: assert property (p_ack) else $error("compare ack ignored");
  property p_ovf; $rose(overflow_irq) |-> $past(timer_tick) || $past(en_wr); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow off tick");
  property p_rdz; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
endmodule : tocu_checker
bind tocu_top tocu_checker tocu_checker_inst (.clk(clk), .arst_n(arst_n),
  .timer_tick(timer_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .compare_irq_ack(compare_irq_ack),
  .overflow_irq_ack(overflow_irq_ack), .port_data(port_data),
  .output_pin_direction_bit(output_pin_direction_bit), .compare_output(compare_output),
  .compare_output_oe(compare_output_oe), .compare_irq(compare_irq),
  .overflow_irq(overflow_irq));
`default_nettype wire

// *** tb/tocu_pin_load.sv ***
// Load on the compare output pin
`timescale 1ns/100ps
`default_nettype none
module tocu_pin_load
(
  input wire logic compare_output,
  input wire logic compare_output_oe,
  output logic pin_level
);
  // ****
  // Pin level
  // ****
  // Pull-down wins while the pin is an input, so a floating pin reads low
  assign pin_level = compare_output_oe ? compare_output : 1'b0;
endmodule : tocu_pin_load
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench for the timer output compare unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} tocu_row_t;
  logic clk = 1'b0, arst_n = 1'b0, timer_tick = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic compare_irq_ack = 1'b0, overflow_irq_ack = 1'b0, port_data = 1'b0;
  logic output_pin_direction_bit = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic compare_output, compare_output_oe, compare_irq, overflow_irq, pin_level;
  int n_mismatch = 0;
  int check_count = 0;
  tocu_row_t rows [4] = '{'{3'h0, 8'h5A, 8'h5A}, '{3'h1, 8'h33, 8'h33},
    '{3'h4, 8'h03, 8'h03}, '{3'h5, 8'hA5, 8'h00}};
  // Control writes beside expected output state, bit 8
  logic [8:0] frc [8] = '{9'h18C, 9'h088, 9'h184, 9'h084, 9'h004, 9'h18C, 9'h10F, 9'h18E};
  // ****
  // Clock, design and pin load
  // ****
  always #25 clk = ~clk;
  tocu_top tocu_top_inst (.clk(clk), .arst_n(arst_n), .timer_tick(timer_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .compare_irq_ack(compare_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .port_data(port_data),
    .output_pin_direction_bit(output_pin_direction_bit), .compare_output(compare_output),
    .compare_output_oe(compare_output_oe), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq));
  tocu_pin_load tocu_pin_load_inst (.compare_output(compare_output),
    .compare_output_oe(compare_output_oe), .pin_level(pin_level));
  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Bus cycles start just after an edge, strobe drops at the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask : rd
  // One-cycle tick with an idle cycle after it, like a slow prescaler
  task automatic tk(input int n);
    repeat (n)
    begin
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask : tk
  // Service pulse on both interrupt acknowledges
  task automatic ack;
    compare_irq_ack <= 1'b1;
    overflow_irq_ack <= 1'b1;
    @(posedge clk);
    compare_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
    #1;
  endtask : ack
  task automatic conclude;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Guard against a hang
  initial
  begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Wrap from the top of the count
    wr(3'h4, 8'h02);
    wr(3'h0, 8'hFE);
    wr(3'h2, 8'h10);
    tk(1);
    rd(3'h0, 8'hFF);
    chk("overflow_irq", overflow_irq, 1'h0);
    tk(1);
    chk("overflow_irq", overflow_irq, 1'h1);
    rd(3'h0, 8'h00);
    rd(3'h3, 8'h02);
    ack();
    chk("overflow_irq", overflow_irq, 1'h0);
    // Match flag lags the match by one tick
    wr(3'h1, 8'h10);
    wr(3'h0, 8'h0E);
    wr(3'h4, 8'h01);
    tk(2);
    chk("compare_irq", compare_irq, 1'h0);
    tk(1);
    chk("compare_irq", compare_irq, 1'h1);
    wr(3'h3, 8'h01);
    chk("compare_irq", compare_irq, 1'h0);
    // Counter written equal to compare value
    wr(3'h1, 8'h20);
    wr(3'h0, 8'h20);
    tk(2);
    rd(3'h3, 8'h00);
    wr(3'h2, 8'h00);
    port_data <= 1'b1;
    @(posedge clk);
    #1;
    chk("compare_output", compare_output, 1'h1);
    port_data <= 1'b0;
    foreach (frc[i])
    begin
      wr(3'h2, frc[i][7:0]);
      chk("compare_output", compare_output, frc[i][8]);
    end
    rd(3'h3, 8'h00);
    chk("pin_level", pin_level, 1'h0);
    output_pin_direction_bit <= 1'b1;
    @(posedge clk);
    #1;
    chk("pin_level", pin_level, 1'h1);
    // Real matches with no action, then with toggle
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h1F);
    tk(3);
    wr(3'h2, 8'h14);
    chk("compare_output", compare_output, 1'h1);
    wr(3'h0, 8'h1F);
    tk(3);
    chk("compare_output", compare_output, 1'h0);
    chk("compare_irq", compare_irq, 1'h1);
    ack();
    chk("compare_irq", compare_irq, 1'h0);
    wr(3'h2, 8'h03);
    wr(3'h1, 8'h40);
    rd(3'h1, 8'h40);
    // Active value kept while buffered, loaded at the max tick
    wr(3'h2, 8'h00);
    rd(3'h1, 8'h20);
    wr(3'h2, 8'h13);
    wr(3'h0, 8'hFE);
    tk(2);
    rd(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    rd(3'h1, 8'h40);
    // Clear on match, then dual-slope turn at max
    wr(3'h1, 8'h05);
    wr(3'h0, 8'h04);
    wr(3'h2, 8'h12);
    tk(2);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'hFE);
    wr(3'h2, 8'h11);
    tk(2);
    rd(3'h0, 8'hFE);
    // Second reset in mid-run
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    for (int a = 0; a < 5; a++)
      rd(3'(a), 8'h00);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
